// File: hdl/pirq_regs.svh
// register offsets, field positions, reset values and masks of the interrupt enable bank
`ifndef PIRQ_REGS_SVH
`define PIRQ_REGS_SVH

// ****************************************************************
// register byte offsets (low address byte, bits 1:0 ignored)
// ****************************************************************
`define PIRQ_OFF_ENABLE      8'h00
`define PIRQ_OFF_FLAGS       8'h04
`define PIRQ_OFF_CTRL        8'h08
`define PIRQ_OFF_STATUS      8'h0c

// ****************************************************************
// enable and flag register field positions (same layout)
// ****************************************************************
`define PIRQ_BIT_CAPTURE4    5
`define PIRQ_BIT_CAPTURE3    4
`define PIRQ_BIT_TIMER6      3
`define PIRQ_BIT_TIMER4      1
`define PIRQ_IMPL_MASK       8'h3a

// ****************************************************************
// control and status register field positions
// ****************************************************************
`define PIRQ_CTRL_BIT_MASTER 0
`define PIRQ_CTRL_BIT_GLOBAL 1
`define PIRQ_STAT_BIT_IRQ    8

// ****************************************************************
// reset values
// ****************************************************************
`define PIRQ_ENABLE_RESET    8'h00
`define PIRQ_FLAGS_RESET     8'h00
`define PIRQ_CTRL_RESET      1'b0
`define PIRQ_RDATA_RESET     32'h0000_0000

// ****************************************************************
// bus response codes
// ****************************************************************
`define PIRQ_RESP_OKAY       2'b00
`define PIRQ_RESP_SLVERR     2'b10

`endif

// File: hdl/pirq_pkg.sv
// types shared by the interrupt enable bank modules
package pirq_pkg;

  // ****************************************************************
  // write channel state, gray coded along both entry paths
  // ****************************************************************
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } pirq_wr_state_type;

  // decoded register select
  typedef enum logic [2:0] {
    SEL_ENABLE = 3'h0,
    SEL_FLAGS  = 3'h1,
    SEL_CTRL   = 3'h2,
    SEL_STATUS = 3'h3,
    SEL_NONE   = 3'h4
  } pirq_sel_type;

  // ****************************************************************
  // state of the top module
  // ****************************************************************
  typedef struct packed {
    pirq_wr_state_type wr_state;
    pirq_sel_type      aw_sel;
    logic [7:0]        w_data;
    logic              w_strb0;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        enable;
    logic              master_en;
    logic              global_en;
    logic              irq;
  } pirq_state_type;

  // state of the flag bank
  typedef struct packed {
    logic [7:0] flags;
  } pirq_flag_state_type;

endpackage

// File: hdl/pirq_flag_bank.sv
// sticky source flags: set by events, cleared by writing ones
`timescale 1ns/100ps
`include "pirq_regs.svh"

module pirq_flag_bank
  import pirq_pkg::*;
#(
  parameter logic [7:0] IMPL_MASK = `PIRQ_IMPL_MASK
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       aclken,
  // set and clear vectors
  input  wire logic [7:0] set_vec,
  input  wire logic [7:0] clear_vec,
  // flag state
  output logic      [7:0] flags
);

  pirq_flag_state_type st_reg;
  pirq_flag_state_type st_next;

  // ****************************************************************
  // next flag value
  // ****************************************************************

  // set regardless enables
  // a set in the clear cycle wins so no event is lost
  always_comb begin
    st_next       = st_reg;
    st_next.flags = ((st_reg.flags & ~clear_vec) | set_vec) & IMPL_MASK;
  end

  // register, frozen while the clock enable is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.flags <= `PIRQ_FLAGS_RESET;
    end else if (aclken) begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  set_wins_a: assert property (
    aclken && (set_vec != 8'h00) |=> ((flags & $past(set_vec) & IMPL_MASK) == ($past(set_vec) & IMPL_MASK)))
    else $error("flag set lost against a clear");

endmodule

// File: hdl/pirq_enable_bank3.sv
// third peripheral interrupt enable bank with axi4-lite register access
// Summary of operation
// - bit 5 gates capture unit 4 interrupt
// - bit 4 gates capture unit 3 interrupt
// - bit 3 gates timer 6 match interrupt
// - bit 1 gates timer 4 match interrupt
// - bits 7,6,2,0 ignore writes, read zero
// - enable bits read/write, clear on reset
// - no request without peripheral master enable
// - flags set whatever enables say
`timescale 1ns/100ps
`include "pirq_regs.svh"

module pirq_enable_bank3
  import pirq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset and clock enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              aclken,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // axi4-lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // axi4-lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  // axi4-lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // peripheral event pulses
  input  wire logic              capture_unit4_event,
  input  wire logic              capture_unit3_event,
  input  wire logic              timer6_match_event,
  input  wire logic              timer4_match_event,
  // request to the core
  output logic                   irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pirq_state_type st_reg;
  pirq_state_type st_next;

  logic [7:0]     flags;        // sticky source flags
  logic [7:0]     event_vec;    // events placed at their bit positions
  logic [7:0]     flag_clear;   // write-one-to-clear vector
  logic           aw_take;      // write address handshake
  logic           w_take;       // write data handshake
  logic           ar_take;      // read address handshake
  logic           wr_commit;    // address and data both present
  pirq_sel_type   cur_sel;      // select of the write being committed
  logic [7:0]     cur_data;     // data of the write being committed
  logic           cur_strb0;    // low byte lane of that write
  logic           req_now;      // gated request from current state

  // ****************************************************************
  // functions
  // ****************************************************************

  // map a byte address to a register select
  function automatic pirq_sel_type decode_addr(input logic [ADDR_W-1:0] addr);
    logic [7:0] offs;
    offs = {addr[7:2], 2'b00};
    if ((addr >> 8) != '0) begin
      decode_addr = SEL_NONE;
    end else if (offs == `PIRQ_OFF_ENABLE) begin
      decode_addr = SEL_ENABLE;
    end else if (offs == `PIRQ_OFF_FLAGS) begin
      decode_addr = SEL_FLAGS;
    end else if (offs == `PIRQ_OFF_CTRL) begin
      decode_addr = SEL_CTRL;
    end else if (offs == `PIRQ_OFF_STATUS) begin
      decode_addr = SEL_STATUS;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction

  // gated request: any flag with enable, both masters on
  function automatic logic gated_req(input logic [7:0] flg,
                                     input logic [7:0] ena,
                                     input logic       master,
                                     input logic       global_on);
    gated_req = (|(flg & ena & `PIRQ_IMPL_MASK)) && master && global_on;
  endfunction

  // ****************************************************************
  // source flags
  // ****************************************************************

  // events go to the same positions as their enable bits
  always_comb begin
    event_vec                     = 8'h00;
    event_vec[`PIRQ_BIT_CAPTURE4] = capture_unit4_event;
    event_vec[`PIRQ_BIT_CAPTURE3] = capture_unit3_event;
    event_vec[`PIRQ_BIT_TIMER6]   = timer6_match_event;
    event_vec[`PIRQ_BIT_TIMER4]   = timer4_match_event;
  end

  pirq_flag_bank #(
    .IMPL_MASK (`PIRQ_IMPL_MASK)
  ) u_flags (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .aclken    (aclken),
    .set_vec   (event_vec),
    .clear_vec (flag_clear),
    .flags     (flags)
  );

  // ****************************************************************
  // bus handshakes
  // ****************************************************************

  // readies only while state may advance
  assign awready = aclken && ((st_reg.wr_state == WR_IDLE) || (st_reg.wr_state == WR_DATA));
  assign wready  = aclken && ((st_reg.wr_state == WR_IDLE) || (st_reg.wr_state == WR_ADDR));
  assign arready = aclken && !st_reg.rvalid;
  assign bvalid  = aclken && (st_reg.wr_state == WR_RESP);
  assign rvalid  = aclken && st_reg.rvalid;

  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign ar_take = arvalid && arready;

  // the write commits once both halves are held or arriving
  assign wr_commit = ((st_reg.wr_state == WR_IDLE) && aw_take && w_take) ||
                     ((st_reg.wr_state == WR_ADDR) && w_take) ||
                     ((st_reg.wr_state == WR_DATA) && aw_take);
  assign cur_sel   = aw_take ? decode_addr(awaddr) : st_reg.aw_sel;
  assign cur_data  = w_take ? wdata[7:0] : st_reg.w_data;
  assign cur_strb0 = w_take ? wstrb[0] : st_reg.w_strb0;
  assign req_now   = gated_req(flags, st_reg.enable, st_reg.master_en, st_reg.global_en);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next    = st_reg;
    flag_clear = 8'h00;

    // write channel sequencing
    unique case (st_reg.wr_state)
      WR_IDLE: begin
        if (aw_take && w_take) begin
          st_next.wr_state = WR_RESP;
        end else if (aw_take) begin
          st_next.wr_state = WR_ADDR;
        end else if (w_take) begin
          st_next.wr_state = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (w_take) begin
          st_next.wr_state = WR_RESP;
        end
      end
      WR_DATA: begin
        if (aw_take) begin
          st_next.wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (bready) begin
          st_next.wr_state = WR_IDLE;
        end
      end
    endcase

    // hold whichever half arrived first
    if (aw_take) begin
      st_next.aw_sel = decode_addr(awaddr);
    end
    if (w_take) begin
      st_next.w_data  = wdata[7:0];
      st_next.w_strb0 = wstrb[0];
    end

    // register effects of a committed write, low byte lane only
    if (wr_commit) begin
      st_next.bresp = (cur_sel == SEL_NONE) ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
      if (cur_strb0) begin
        unique case (cur_sel)
          SEL_ENABLE: st_next.enable = cur_data & `PIRQ_IMPL_MASK;
          SEL_FLAGS: flag_clear = cur_data & `PIRQ_IMPL_MASK;
          SEL_CTRL: begin
            st_next.master_en = cur_data[`PIRQ_CTRL_BIT_MASTER];
            st_next.global_en = cur_data[`PIRQ_CTRL_BIT_GLOBAL];
          end
          SEL_STATUS: st_next.enable = st_reg.enable;   // read-only
          SEL_NONE: st_next.enable = st_reg.enable;     // refused
        endcase
      end
    end

    // read channel: one outstanding read, data held until taken
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `PIRQ_RESP_OKAY;
      st_next.rdata  = `PIRQ_RDATA_RESET;
      unique case (decode_addr(araddr))
        SEL_ENABLE: st_next.rdata[7:0] = st_reg.enable & `PIRQ_IMPL_MASK;
        SEL_FLAGS: st_next.rdata[7:0] = flags;
        SEL_CTRL: begin
          st_next.rdata[`PIRQ_CTRL_BIT_MASTER] = st_reg.master_en;
          st_next.rdata[`PIRQ_CTRL_BIT_GLOBAL] = st_reg.global_en;
        end
        SEL_STATUS: begin
          st_next.rdata[7:0]               = flags & st_reg.enable;
          st_next.rdata[`PIRQ_STAT_BIT_IRQ] = st_reg.irq;
        end
        SEL_NONE: st_next.rresp = `PIRQ_RESP_SLVERR;
      endcase
    end

    st_next.irq = req_now;
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg.wr_state  <= WR_IDLE;
      st_reg.aw_sel    <= SEL_NONE;
      st_reg.w_data    <= 8'h00;
      st_reg.w_strb0   <= 1'b0;
      st_reg.bresp     <= `PIRQ_RESP_OKAY;
      st_reg.rvalid    <= 1'b0;
      st_reg.rdata     <= `PIRQ_RDATA_RESET;
      st_reg.rresp     <= `PIRQ_RESP_OKAY;
      st_reg.enable    <= `PIRQ_ENABLE_RESET;
      st_reg.master_en <= `PIRQ_CTRL_RESET;
      st_reg.global_en <= `PIRQ_CTRL_RESET;
      st_reg.irq       <= 1'b0;
    end else if (aclken) begin
      st_reg <= st_next;
    end
  end

  // outputs from flip-flops
  assign bresp = st_reg.bresp;
  assign rdata = st_reg.rdata;
  assign rresp = st_reg.rresp;
  assign irq   = st_reg.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cap4_allow_a: assert property (
    aclken && flags[`PIRQ_BIT_CAPTURE4] && st_reg.enable[`PIRQ_BIT_CAPTURE4] &&
    st_reg.master_en && st_reg.global_en |=> irq)
    else $error("enabled capture unit 4 flag gave no request");

  cap3_block_a: assert property (
    aclken && (flags == 8'h10) && !st_reg.enable[`PIRQ_BIT_CAPTURE3] |=> !irq)
    else $error("disabled capture unit 3 flag raised a request");

  tmr6_allow_a: assert property (
    aclken && flags[`PIRQ_BIT_TIMER6] && st_reg.enable[`PIRQ_BIT_TIMER6] &&
    st_reg.master_en && st_reg.global_en |=> irq)
    else $error("enabled timer 6 flag gave no request");

  tmr4_gate_a: assert property (
    aclken && (flags == 8'h02) && st_reg.master_en && st_reg.global_en
    |=> (irq == $past(st_reg.enable[`PIRQ_BIT_TIMER4])))
    else $error("timer 4 request does not follow its enable");

  unused_zero_a: assert property (
    ((st_reg.enable & ~`PIRQ_IMPL_MASK) == 8'h00) &&
    (!(st_reg.rvalid && $past(ar_take) && ($past(decode_addr(araddr)) == SEL_ENABLE)) ||
     ((st_reg.rdata & 32'hffff_ffc5) == 32'h0000_0000)))
    else $error("unused enable bit is set or read back");

  enable_write_a: assert property (
    aclken && wr_commit && cur_strb0 && (cur_sel == SEL_ENABLE)
    |=> (st_reg.enable == ($past(cur_data) & `PIRQ_IMPL_MASK)))
    else $error("enable write not stored");

  reset_clear_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (st_reg.enable == 8'h00) && !irq)
    else $error("enable bank not cleared by reset");

  master_gate_a: assert property (
    aclken && !st_reg.master_en |=> !irq)
    else $error("request raised with peripheral master enable off");

  flag_set_a: assert property (
    aclken && timer4_match_event && !st_reg.enable[`PIRQ_BIT_TIMER4]
    |=> flags[`PIRQ_BIT_TIMER4])
    else $error("timer 4 flag not set while disabled");

  irq_cause_a: assert property (
    $rose(irq) |-> $past(req_now) && $past(aclken))
    else $error("request rose without flag, enable and masters");

  bresp_hold_a: assert property (
    bvalid && !bready ##1 aclken |-> $stable(bresp))
    else $error("write response changed while waiting");

  // main scenarios
  irq_seen_c:    cover property ($rose(irq));
  write_pair_c:  cover property (aclken && (st_reg.wr_state == WR_IDLE) && aw_take && w_take);
  data_first_c:  cover property (aclken && (st_reg.wr_state == WR_DATA) && aw_take);
  read_stall_c:  cover property (rvalid && !rready ##1 rvalid && rready);

endmodule

// File: tb/pirq_event_source.sv
// model of the peripheral event sources feeding the enable bank
`timescale 1ns/100ps

module pirq_event_source (
  // clock
  input  wire logic       aclk,
  // event pulses: capture4, capture3, timer6, timer4
  output logic      [3:0] ev
);
  initial ev = 4'h0;

  // events ignore enables
  // sources fire whenever their condition occurs, one cycle wide
  task automatic pulse(input logic [3:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 4'h0;
  endtask
endmodule

// File: tb/pirq_enable_bank3_test.sv
// self-checking bench for the third interrupt enable bank
`timescale 1ns/100ps
`include "pirq_regs.svh"

module pirq_enable_bank3_test;
  localparam logic [7:0] EN = `PIRQ_OFF_ENABLE;
  localparam logic [7:0] FL = `PIRQ_OFF_FLAGS;
  localparam logic [7:0] CT = `PIRQ_OFF_CTRL;
  localparam logic [7:0] ST = `PIRQ_OFF_STATUS;
  localparam logic [1:0] OK = `PIRQ_RESP_OKAY;
  localparam logic [1:0] SE = `PIRQ_RESP_SLVERR;
  // enable bit position of each event line
  localparam int         BITS [4] = '{1, 3, 4, 5};

  logic        aclk, aresetn, aclken;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, ev;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [1:0]  bresp, rresp;
  int          bad_count, checks_done;

  // ****************************************************************
  // design, event sources and clock
  // ****************************************************************
  pirq_enable_bank3 #(.ADDR_W(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .aclken(aclken),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_unit4_event(ev[3]), .capture_unit3_event(ev[2]),
    .timer6_match_event(ev[1]), .timer4_match_event(ev[0]),
    .irq(irq)
  );

  pirq_event_source src (.aclk(aclk), .ev(ev));

  // free-running 250 MHz clock
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  // ****************************************************************
  // reporting and bus tasks
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // a wait that runs out ends the run
  task automatic stall;
    $display("ERROR at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    bad_count++;
    finish_test();
  endtask

  // write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs, bv;
    int   n;
    n = 0;
    b_hs = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // bready only once the response shows, so a waiting response is exercised
    while (!b_hs) begin
      if (n == 50) stall();
      n++;
      @(negedge aclk);
      aw_hs = awvalid && awready === 1'b1;
      w_hs = wvalid && wready === 1'b1;
      bv = bvalid === 1'b1;
      b_hs = bready && bv;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (bv && !b_hs) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask

  // read: address held until taken, rready until rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    int   n;
    n = 0;
    r_hs = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs) begin
      if (n == 50) stall();
      n++;
      @(negedge aclk);
      ar_hs = arvalid && arready === 1'b1;
      r_hs = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check({30'h0, r}, {30'h0, OK});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, er});
  endtask

  // irq looked at mid-cycle, once settled
  task automatic irq_is(input logic e);
    @(negedge aclk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [1:0] r;
    rchk(EN, 32'h0, OK);
    rchk(FL, 32'h0, OK);
    rchk(ST, 32'h0, OK);
    irq_is(1'b0);
    wok(EN, 32'hff);
    rchk(EN, 32'h3a, OK);
    wok(EN, 32'h45);
    rchk(EN, 32'h0, OK);
    wok(CT, 32'h3);
    rchk(CT, 32'h3, OK);
    wok(ST, 32'hff);
    rchk(ST, 32'h0, OK);
    wr(8'h10, 32'hff, r);
    check({30'h0, r}, {30'h0, SE});
    rchk(8'h10, 32'h0, SE);
    $display("register access test done");
  endtask

  // one source: flag always set, request only with its own bit
  task automatic t_gate(input int i);
    logic [31:0] b;
    b = 32'h1 << BITS[i];
    wok(FL, 32'hff);
    wok(CT, 32'h3);
    wok(EN, 32'h0);
    src.pulse(4'h1 << i);
    @(posedge aclk);
    irq_is(1'b0);
    rchk(FL, b, OK);
    wok(FL, b);
    wok(EN, b);
    src.pulse(4'h1 << i);
    @(posedge aclk);
    irq_is(1'b1);
    rchk(ST, 32'h100 | b, OK);
    wok(EN, 32'h3a ^ b);
    irq_is(1'b0);
    wok(FL, b);
    wok(EN, 32'h0);
    $display("gate test %0d done", i);
  endtask

  // master and global enables both needed for a request
  task automatic t_master;
    wok(FL, 32'hff);
    wok(EN, 32'h3a);
    wok(CT, 32'h2);
    src.pulse(4'hf);
    @(posedge aclk);
    irq_is(1'b0);
    rchk(ST, 32'h3a, OK);
    wok(CT, 32'h1);
    irq_is(1'b0);
    wok(CT, 32'h3);
    irq_is(1'b1);
    wok(FL, 32'hff);
    irq_is(1'b0);
    $display("master enable test done");
  endtask

  // clock enable low: readies drop and events are ignored
  task automatic t_freeze;
    wok(FL, 32'hff);
    @(posedge aclk);
    aclken <= 1'b0;
    src.pulse(4'hf);
    @(negedge aclk);
    check({31'h0, arready}, 32'h0);
    check({31'h0, irq}, 32'h0);
    @(posedge aclk);
    aclken <= 1'b1;
    rchk(FL, 32'h0, OK);
    $display("clock enable test done");
  endtask

  // reset in mid-run clears every enable
  task automatic t_rerun;
    wok(EN, 32'h3a);
    src.pulse(4'hf);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(EN, 32'h0, OK);
    rchk(CT, 32'h0, OK);
    rchk(FL, 32'h0, OK);
    irq_is(1'b0);
    $display("mid-run reset test done");
  endtask

  // main sequence
  initial begin
    bad_count = 0;
    checks_done = 0;
    aresetn = 1'b0;
    aclken = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_gate(0);
    t_gate(1);
    t_gate(2);
    t_gate(3);
    t_master();
    t_freeze();
    t_rerun();
    finish_test();
  end
endmodule
